// File: tb/test_vdsr_regs.sv
// Self-checking bench for the video status and format register bank
`timescale 1ns/1ps
`include "vdsr_map.svh"
module test_vdsr_regs;
    // Short detector counts keep the run brief
    localparam int NL = 4;
    localparam logic [7:0] STD_TBL = 8'he8;
    logic ref_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [9:0] addr;
    logic [3:0] be;
    logic wr, rd;
    logic [31:0] wdata, rdata, q, d, e;
    logic tick = 1'b0, sync = 1'b0, win = 1'b0, fe = 1'b0, fend = 1'b0, f625 = 1'b0;
    logic pll = 1'b0, lovf = 1'b0, covf = 1'b0, ok, s625;
    logic ce = 1'b1;
    logic [3:0] asel;
    logic [2:0] fmt;
    int num_errors = 0, cmp_count = 0, n_ns, n_hl, n_nl;
    logic [31:0] seed = 32'h18b7553b;
    logic [7:0] m_fmt;
    logic m_video_present_flag, m_hl, m_nl, m_lof, m_cof;

    // 125 MHz clock
    always #4 ref_clk_i = ~ref_clk_i;

    vdsr_regs #(.NO_SYNC_LINES(NL), .HLOCK_LINES(NL), .STD_FIELDS(NL)) i_vdsr_regs (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .ce_i(ce), .reg_addr_i(addr),
        .reg_be_i(be), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .line_tick_i(tick), .sync_seen_i(sync),
        .sync_in_window_i(win), .field_even_i(fe), .field_end_i(fend),
        .field_625_i(f625), .pll_unlocked_i(pll), .luma_ovf_i(lovf),
        .chroma_ovf_i(covf), .analog_input_sel_o(asel), .format_o(fmt), .std_625_o(s625));

    vdsr_host_model i_vdsr_host_model (.ref_clk_i(ref_clk_i), .reg_addr_o(addr),
        .reg_be_o(be), .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wdata),
        .reg_rdata_i(rdata));

    // ========
    // Model and helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Selector 00->3, 01->2, 10->0, 11->1; auto follows the line-count flag
    function automatic logic [7:0] outs();
        logic [3:0] a;
        a = 4'h1 << {~m_fmt[6], ~(m_fmt[6] ^ m_fmt[5])};
        return {a, m_fmt[2:0], (m_fmt[2:0] == 3'h0) ? m_nl : STD_TBL[m_fmt[2:0]]};
    endfunction

    task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %0t read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %0t outputs %h expected %h", $time, got, exp);
        end
    endtask

    task automatic do_reset();
        rst_b_i = 1'b0;
        repeat (5) @(negedge ref_clk_i);
        rst_b_i = 1'b1;
        m_fmt = `VDSR_FORMAT_RESET;
        {m_video_present_flag, m_hl, m_nl, m_lof, m_cof} = '0;
        {n_ns, n_hl, n_nl} = '0;
    endtask

    // Live bits are randomised before every read
    task automatic rd_chk(input logic [9:0] a, input logic [3:0] b);
        e = rnd();
        fe = e[0];
        pll = e[1];
        i_vdsr_host_model.access(1'b0, a, b, e, q);
        if (!b[0])
            e = 32'h0;
        else if (a == `VDSR_DECODER_STATUS_IDX)
            e = {24'h0, m_video_present_flag, m_hl, fe, m_nl, 1'b0, pll, m_lof, m_cof};
        else if (a == `VDSR_INPUT_FORMAT_SELECT_IDX)
            e = {24'h0, m_fmt};
        else
            e = 32'h0;
        chk_rd(q, e);
    endtask

    task automatic wr_reg(input logic [9:0] a, input logic [3:0] b, input logic [31:0] v);
        if (b[0] && a == `VDSR_DECODER_STATUS_IDX)
            {m_lof, m_cof} = 2'b00;
        if (b[0] && a == `VDSR_INPUT_FORMAT_SELECT_IDX)
            m_fmt = {1'b0, v[6:5], 2'b11, v[2:0]};
        i_vdsr_host_model.access(1'b1, a, b, v, q);
    endtask

    // One line tick, or one sync pulse, with the model's counts
    task automatic line(input logic s, input logic w);
        @(negedge ref_clk_i);
        sync = s;
        tick = !s;
        win = w;
        @(negedge ref_clk_i);
        {sync, tick, win} = {2'b00, ~w};
        n_ns = s ? 0 : n_ns + 1;
        n_hl = (s || w == m_hl) ? 0 : n_hl + 1;
        m_video_present_flag = s ? 1'b1 : (n_ns >= NL ? 1'b0 : m_video_present_flag);
        m_hl = (n_hl == NL) ? w : m_hl;
        n_hl = (n_hl == NL) ? 0 : n_hl;
    endtask

    task automatic field(input logic f);
        @(negedge ref_clk_i);
        {fend, f625} = {1'b1, f};
        @(negedge ref_clk_i);
        {fend, f625} = {1'b0, ~f};
        n_nl = (f == m_nl) ? 0 : n_nl + 1;
        m_nl = (n_nl == NL) ? f : m_nl;
        n_nl = (n_nl == NL) ? 0 : n_nl;
    endtask

    // Overflow pulse, optionally on the same edge as a clearing write
    task automatic ovf(input logic l, input logic c, input logic w);
        fork
            begin
                @(negedge ref_clk_i);
                {lovf, covf} = {l, c};
                @(negedge ref_clk_i);
                {lovf, covf} = 2'b00;
            end
            if (w) wr_reg(`VDSR_DECODER_STATUS_IDX, 4'h1, rnd());
        join
        m_lof |= l;
        m_cof |= c;
    endtask

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ========
    // Main sequence
    initial
    begin
        do_reset();
        // Control outputs load from the format register one edge after release
        @(negedge ref_clk_i);
        chk_out({asel, fmt, s625}, outs());
        rd_chk(`VDSR_DECODER_STATUS_IDX, 4'hf);
        rd_chk(`VDSR_INPUT_FORMAT_SELECT_IDX, 4'hf);
        rd_chk(10'h3a5, 4'h1);
        for (int i = 0; i < 8; i++)
        begin
            d = rnd();
            e = rnd();
            wr_reg(`VDSR_INPUT_FORMAT_SELECT_IDX, {e[3:1], 1'b1},
                {d[31:7], i[1:0], d[4:3], i[2:0]});
            rd_chk(`VDSR_INPUT_FORMAT_SELECT_IDX, 4'h1);
            chk_out({asel, fmt, s625}, outs());
        end
        wr_reg(`VDSR_INPUT_FORMAT_SELECT_IDX, 4'he, rnd());
        rd_chk(`VDSR_INPUT_FORMAT_SELECT_IDX, 4'h0);
        rd_chk(`VDSR_INPUT_FORMAT_SELECT_IDX, 4'h1);
        // A write while the clock enable is low must not land
        ce = 1'b0;
        i_vdsr_host_model.access(1'b1, `VDSR_INPUT_FORMAT_SELECT_IDX, 4'h1, 32'h23, q);
        ce = 1'b1;
        rd_chk(`VDSR_INPUT_FORMAT_SELECT_IDX, 4'h1);
        wr_reg(`VDSR_INPUT_FORMAT_SELECT_IDX, 4'h1, 32'h0);
        line(1'b1, 1'b1);
        rd_chk(`VDSR_DECODER_STATUS_IDX, 4'h1);
        repeat (NL) line(1'b0, 1'b1);
        rd_chk(`VDSR_DECODER_STATUS_IDX, 4'h1);
        wr_reg(`VDSR_DECODER_STATUS_IDX, 4'h1, 32'h0);
        rd_chk(`VDSR_DECODER_STATUS_IDX, 4'h1);
        repeat (NL - 1) line(1'b0, 1'b0);
        line(1'b0, 1'b1);
        repeat (NL) line(1'b0, 1'b0);
        rd_chk(`VDSR_DECODER_STATUS_IDX, 4'h1);
        repeat (NL - 1) field(1'b1);
        field(1'b0);
        rd_chk(`VDSR_DECODER_STATUS_IDX, 4'h1);
        repeat (NL) field(1'b1);
        rd_chk(`VDSR_DECODER_STATUS_IDX, 4'h1);
        chk_out({asel, fmt, s625}, outs());
        ovf(1'b1, 1'b0, 1'b0);
        rd_chk(`VDSR_DECODER_STATUS_IDX, 4'h1);
        ovf(1'b0, 1'b1, 1'b0);
        rd_chk(`VDSR_DECODER_STATUS_IDX, 4'h1);
        wr_reg(`VDSR_DECODER_STATUS_IDX, 4'h1, rnd());
        rd_chk(`VDSR_DECODER_STATUS_IDX, 4'h1);
        ovf(1'b1, 1'b1, 1'b1);
        rd_chk(`VDSR_DECODER_STATUS_IDX, 4'h1);
        pll = 1'b1;
        fork
            #200 pll = 1'b0;
            i_vdsr_host_model.poll_pll(ok);
        join
        {m_lof, m_cof} = 2'b00;
        chk_rd({31'h0, ok}, 32'h1);
        do_reset();
        rd_chk(`VDSR_INPUT_FORMAT_SELECT_IDX, 4'h1);
        rd_chk(`VDSR_DECODER_STATUS_IDX, 4'h1);
        stop_test();
    end

    // Watchdog well past the expected few hundred cycles
    initial
    begin
        #200000;
        num_errors++;
        stop_test();
    end
endmodule

// File: tb/vdsr_host_model.sv
// Host software model driving register reads and writes
`timescale 1ns/1ps
`include "vdsr_map.svh"
module vdsr_host_model
(
    // Clock
    input wire logic ref_clk_i,
    // Register access port
    output logic [9:0] reg_addr_o,
    output logic [3:0] reg_be_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [31:0] reg_wdata_o,
    input wire logic [31:0] reg_rdata_i
);
    // ========
    // Quiet bus at time zero
    initial
    begin
        {reg_addr_o, reg_be_o, reg_wr_o, reg_rd_o, reg_wdata_o} = '0;
    end

    // One access; the released bus shows inverted values, never stale ones
    task automatic access(input logic w, input logic [9:0] a, input logic [3:0] b,
        input logic [31:0] d, output logic [31:0] q);
        @(negedge ref_clk_i);
        reg_wr_o = w;
        reg_rd_o = !w;
        reg_addr_o = a;
        reg_be_o = b;
        reg_wdata_o = (a == `VDSR_INPUT_FORMAT_SELECT_IDX) ? {d[31:8], 1'b0, d[6:0]} : d;
        @(negedge ref_clk_i);
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
        reg_be_o = ~b;
        reg_wdata_o = ~d;
        @(negedge ref_clk_i);
        q = reg_rdata_i;
    endtask

    // Write the status word and reread until the live PLL flag clears; bounded so a stuck flag ends it
    task automatic poll_pll(output logic ok);
        logic [31:0] r;
        ok = 1'b0;
        repeat (16)
        begin
            if (!ok)
            begin
                access(1'b1, `VDSR_DECODER_STATUS_IDX, 4'h1, 32'h4, r);
                access(1'b0, `VDSR_DECODER_STATUS_IDX, 4'h1, 32'h0, r);
                ok = !r[2];
            end
        end
    endtask
endmodule

// File: verilog/vdsr_map.svh
// Register offsets, field positions, reset values and detector counts
`ifndef VDSR_MAP_SVH
`define VDSR_MAP_SVH
// ================================================================
// Register word indices (AD[11:2]); byte address is four times these
`define VDSR_DECODER_STATUS_IDX 10'h000
`define VDSR_INPUT_FORMAT_SELECT_IDX 10'h001
// ================================================================
// Status bit positions
`define VDSR_VIDEO_PRESENT_BIT 7
`define VDSR_HORIZONTAL_LOCK_BIT 6
`define VDSR_FIELD_EVEN_BIT 5
`define VDSR_LINE_COUNT_BIT 4
`define VDSR_PLL_UNLOCKED_BIT 2
`define VDSR_LUMA_OVERFLOW_BIT 1
`define VDSR_CHROMA_OVERFLOW_BIT 0
// ================================================================
// Format register fields
`define VDSR_FMT_RSVD_BIT 7
`define VDSR_SEL_MSB 6
`define VDSR_SEL_LSB 5
`define VDSR_FMT_RO_MSB 4
`define VDSR_FMT_RO_LSB 3
`define VDSR_FMT_MSB 2
`define VDSR_FMT_LSB 0
`define VDSR_FMT_RO_VALUE 2'h3
// ================================================================
// Reset values
`define VDSR_STATUS_RESET 8'h00
`define VDSR_FORMAT_RESET 8'h58
// ================================================================
// Detector counts in lines or fields
`define VDSR_NO_SYNC_LINES 31
`define VDSR_HLOCK_LINES 32
`define VDSR_STD_FIELDS 32
`endif

// File: verilog/vdsr_pkg.sv
// Types shared by the video input status and format register bank
package vdsr_pkg;
    // ================================================================
    // Colour standard codes of the format field
    typedef enum logic [2:0] {
        VDSR_FMT_AUTO = 3'h0,
        VDSR_FMT_NTSC_M = 3'h1,
        VDSR_FMT_NTSC_JP = 3'h2,
        VDSR_FMT_PAL_BDGHI = 3'h3,
        VDSR_FMT_PAL_M = 3'h4,
        VDSR_FMT_PAL_N = 3'h5,
        VDSR_FMT_SECAM = 3'h6,
        VDSR_FMT_PAL_NC = 3'h7
    } vdsr_format_t;

    // Horizontal lock detector states
    typedef enum logic [1:0] {
        VDSR_HL_SEEK = 2'b01,
        VDSR_HL_LOCKED = 2'b10
    } vdsr_hlock_t;
endpackage

// File: verilog/vdsr_regs.sv
// Video decoder status and input format register bank
`timescale 1ns/1ps
`include "vdsr_map.svh"
module vdsr_regs
    import vdsr_pkg::*;
#(
    parameter int NO_SYNC_LINES = `VDSR_NO_SYNC_LINES,
    parameter int HLOCK_LINES = `VDSR_HLOCK_LINES,
    parameter int STD_FIELDS = `VDSR_STD_FIELDS
)
(
    // Clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // Register access port
    input wire logic [9:0] reg_addr_i,
    input wire logic [3:0] reg_be_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    // Detector inputs
    input wire logic line_tick_i,
    input wire logic sync_seen_i,
    input wire logic sync_in_window_i,
    input wire logic field_even_i,
    input wire logic field_end_i,
    input wire logic field_625_i,
    input wire logic pll_unlocked_i,
    input wire logic luma_ovf_i,
    input wire logic chroma_ovf_i,
    // Decoder control outputs
    output logic [3:0] analog_input_sel_o,
    output logic [2:0] format_o,
    output logic std_625_o
);

    // ================================================================
    // Access decode
    logic wr_lane0;
    logic wr_status;
    logic wr_format;
    assign wr_lane0 = ce_i && reg_wr_i && reg_be_i[0];
    assign wr_status = wr_lane0 && (reg_addr_i == `VDSR_DECODER_STATUS_IDX);
    assign wr_format = wr_lane0 && (reg_addr_i == `VDSR_INPUT_FORMAT_SELECT_IDX);

    // ================================================================
    // Video present: counts line periods since the last sync
    logic [5:0] nosync_cnt_q;
    logic video_present_flag_q;
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            nosync_cnt_q <= 6'h00;
            video_present_flag_q <= 1'b0;
        end
        else if (ce_i)
        begin
            if (sync_seen_i)
            begin
                nosync_cnt_q <= 6'h00;
                video_present_flag_q <= 1'b1;
            end
            else if (line_tick_i && (nosync_cnt_q != NO_SYNC_LINES[5:0]))
            begin
                nosync_cnt_q <= nosync_cnt_q + 6'h01;
                // Drop on the tick that completes the silent run
                if (nosync_cnt_q == NO_SYNC_LINES[5:0] - 6'h01)
                    video_present_flag_q <= 1'b0;
            end
        end
    end

    // ================================================================
    // Horizontal lock hysteresis; host writes never reach it
    vdsr_hlock_t hl_state_q;
    logic [5:0] hl_cnt_q;
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            hl_state_q <= VDSR_HL_SEEK;
            hl_cnt_q <= 6'h00;
        end
        else if (ce_i && line_tick_i)
        begin
            case (hl_state_q)
                VDSR_HL_SEEK:
                begin
                    if (!sync_in_window_i)
                        hl_cnt_q <= 6'h00;
                    else if (hl_cnt_q == HLOCK_LINES[5:0] - 6'h01)
                    begin
                        hl_cnt_q <= 6'h00;
                        hl_state_q <= VDSR_HL_LOCKED;
                    end
                    else
                        hl_cnt_q <= hl_cnt_q + 6'h01;
                end
                VDSR_HL_LOCKED:
                begin
                    if (sync_in_window_i)
                        hl_cnt_q <= 6'h00;
                    else if (hl_cnt_q == HLOCK_LINES[5:0] - 6'h01)
                    begin
                        hl_cnt_q <= 6'h00;
                        hl_state_q <= VDSR_HL_SEEK;
                    end
                    else
                        hl_cnt_q <= hl_cnt_q + 6'h01;
                end
                default:
                begin
                    hl_state_q <= VDSR_HL_SEEK;
                    hl_cnt_q <= 6'h00;
                end
            endcase
        end
    end
    logic horizontal_lock_flag;
    assign horizontal_lock_flag = (hl_state_q == VDSR_HL_LOCKED);

    // ================================================================
    // Line-count flag: flips only after a run of disagreeing fields
    logic [5:0] std_cnt_q;
    logic line_count_flag_q;
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            std_cnt_q <= 6'h00;
            line_count_flag_q <= 1'b0;
        end
        else if (ce_i && field_end_i)
        begin
            if (field_625_i == line_count_flag_q)
                std_cnt_q <= 6'h00;
            else if (std_cnt_q == STD_FIELDS[5:0] - 6'h01)
            begin
                std_cnt_q <= 6'h00;
                line_count_flag_q <= field_625_i;
            end
            else
                std_cnt_q <= std_cnt_q + 6'h01;
        end
    end

    // ================================================================
    // Sticky overflow flags; an overflow beats a clearing write
    logic luma_overflow_flag_q;
    logic chroma_overflow_flag_q;
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            luma_overflow_flag_q <= 1'b0;
            chroma_overflow_flag_q <= 1'b0;
        end
        else if (ce_i)
        begin
            if (luma_ovf_i)
                luma_overflow_flag_q <= 1'b1;
            else if (wr_status)
                luma_overflow_flag_q <= 1'b0;
            if (chroma_ovf_i)
                chroma_overflow_flag_q <= 1'b1;
            else if (wr_status)
                chroma_overflow_flag_q <= 1'b0;
        end
    end

    // Live bits are wired straight from their detectors
    logic [7:0] decoder_status;
    always_comb
    begin
        decoder_status = 8'h00;
        decoder_status[`VDSR_VIDEO_PRESENT_BIT] = video_present_flag_q;
        decoder_status[`VDSR_HORIZONTAL_LOCK_BIT] = horizontal_lock_flag;
        decoder_status[`VDSR_FIELD_EVEN_BIT] = field_even_i;
        decoder_status[`VDSR_LINE_COUNT_BIT] = line_count_flag_q;
        decoder_status[`VDSR_PLL_UNLOCKED_BIT] = pll_unlocked_i;
        decoder_status[`VDSR_LUMA_OVERFLOW_BIT] = luma_overflow_flag_q;
        decoder_status[`VDSR_CHROMA_OVERFLOW_BIT] = chroma_overflow_flag_q;
    end

    // ================================================================
    // Input format register; bits 4:3 are constant and not stored
    logic fmt_rsvd_q;
    logic [1:0] input_selector_q;
    logic [2:0] format_q;
    localparam logic [7:0] FMT_RST = `VDSR_FORMAT_RESET;
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            fmt_rsvd_q <= FMT_RST[`VDSR_FMT_RSVD_BIT];
            input_selector_q <= FMT_RST[`VDSR_SEL_MSB:`VDSR_SEL_LSB];
            format_q <= FMT_RST[`VDSR_FMT_MSB:`VDSR_FMT_LSB];
        end
        else if (wr_format)
        begin
            // Bit 7 is stored as written; software keeps it at zero
            fmt_rsvd_q <= reg_wdata_i[`VDSR_FMT_RSVD_BIT];
            input_selector_q <= reg_wdata_i[`VDSR_SEL_MSB:`VDSR_SEL_LSB];
            format_q <= reg_wdata_i[`VDSR_FMT_MSB:`VDSR_FMT_LSB];
        end
    end
    logic [7:0] input_format_select;
    assign input_format_select = {fmt_rsvd_q, input_selector_q, `VDSR_FMT_RO_VALUE, format_q};

    // ================================================================
    // Input routing and standard choice, registered for clean control
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            analog_input_sel_o <= 4'h0;
            format_o <= 3'h0;
            std_625_o <= 1'b0;
        end
        else if (ce_i)
        begin
            case (input_selector_q)
                2'h0: analog_input_sel_o <= 4'h8;
                2'h1: analog_input_sel_o <= 4'h4;
                2'h2: analog_input_sel_o <= 4'h1;
                2'h3: analog_input_sel_o <= 4'h2;
                default: analog_input_sel_o <= 4'h1;
            endcase
            format_o <= format_q;
            case (vdsr_format_t'(format_q))
                VDSR_FMT_AUTO: std_625_o <= line_count_flag_q;
                VDSR_FMT_NTSC_M, VDSR_FMT_NTSC_JP, VDSR_FMT_PAL_M: std_625_o <= 1'b0;
                VDSR_FMT_PAL_BDGHI, VDSR_FMT_PAL_N, VDSR_FMT_SECAM,
                VDSR_FMT_PAL_NC: std_625_o <= 1'b1;
                default: std_625_o <= 1'b0;
            endcase
        end
    end

    // ================================================================
    // Read data: lane 0 only, upper lanes and unused words read zero
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            reg_rdata_o <= 32'h0000_0000;
        else if (ce_i && reg_rd_i)
        begin
            reg_rdata_o <= 32'h0000_0000;
            if (reg_be_i[0] && reg_addr_i == `VDSR_DECODER_STATUS_IDX)
                reg_rdata_o[7:0] <= decoder_status;
            else if (reg_be_i[0] && reg_addr_i == `VDSR_INPUT_FORMAT_SELECT_IDX)
                reg_rdata_o[7:0] <= input_format_select;
        end
    end

    // ================================================================
    // Checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    a_present_drop: assert property (ce_i && line_tick_i && !sync_seen_i
        && nosync_cnt_q == NO_SYNC_LINES[5:0] - 6'h01 |=> !video_present_flag_q)
        else $error("video present not dropped after silent run");
    a_present_back: assert property (ce_i && sync_seen_i |=> video_present_flag_q)
        else $error("video present not restored on sync");
    a_hlock_write: assert property (wr_status && !(ce_i && line_tick_i)
        |=> $stable(horizontal_lock_flag))
        else $error("host write changed horizontal lock");
    a_std_stable: assert property (!(ce_i && field_end_i)
        |=> $stable(line_count_flag_q))
        else $error("line-count flag moved without a field end");
    a_luma_sticky: assert property (ce_i && luma_ovf_i ##1 !wr_status
        |-> luma_overflow_flag_q ##1 luma_overflow_flag_q)
        else $error("luma overflow flag not held");
    a_chroma_win: assert property (ce_i && chroma_ovf_i && wr_status
        |=> chroma_overflow_flag_q)
        else $error("chroma overflow lost to clearing write");
    a_chroma_clear: assert property (wr_status && !chroma_ovf_i
        |=> !chroma_overflow_flag_q)
        else $error("chroma overflow flag not cleared by write");
    a_mux_route: assert property (ce_i && input_selector_q == 2'h0
        |=> analog_input_sel_o == 4'h8)
        else $error("selector 00 did not route input 3");
    a_auto_std: assert property (ce_i && format_q == 3'h0
        |=> std_625_o == $past(line_count_flag_q))
        else $error("auto mode ignored line-count flag");
    a_upper_zero: assert property (ce_i && reg_rd_i |=> reg_rdata_o[31:8] == 24'h0)
        else $error("upper byte lanes not zero");
    a_pll_live: assert property (ce_i && reg_rd_i && reg_be_i[0]
        && reg_addr_i == `VDSR_DECODER_STATUS_IDX
        |=> reg_rdata_o[`VDSR_PLL_UNLOCKED_BIT] == $past(pll_unlocked_i))
        else $error("pll flag not live");

    c_lock_gain: cover property (!horizontal_lock_flag ##1 horizontal_lock_flag);
    c_std_flip: cover property (!line_count_flag_q ##1 line_count_flag_q);
    c_ovf_clear: cover property (luma_overflow_flag_q ##1 wr_status ##1 !luma_overflow_flag_q);
    c_video_lost: cover property (video_present_flag_q ##1 !video_present_flag_q);

endmodule
